// ===== mip_field.sv
// one 16-bit extended register with per-bit access behaviour
// same clock and synchronised reset as the portal; i_rd marks a read of this register
`timescale 1ns/10ps
`default_nettype none
`include "mip_regs.svh"

module mip_field #(
	parameter logic [15:0] RESET = 16'h0000,
	parameter logic [15:0] RW_MASK = 16'h0000,
	parameter logic [15:0] SC_MASK = 16'h0000,
	parameter logic [15:0] LH_MASK = 16'h0000,
	parameter logic [15:0] LL_MASK = 16'h0000
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_wr,
	input wire logic [15:0] i_wdata,
	input wire logic i_rd,
	input wire logic [15:0] i_hw,
	output var logic [15:0] o_q
);

	localparam logic [15:0] RO_MASK = ~(RW_MASK | SC_MASK | LH_MASK | LL_MASK);

	logic [15:0] q_r;
	logic [15:0] q_nxt;

	always_comb begin
		logic [15:0] rw_v;
		logic [15:0] sc_v;
		logic [15:0] lh_v;
		logic [15:0] ll_v;
		rw_v = i_wr ? i_wdata : q_r;
		sc_v = i_wr ? i_wdata : '0;
		// hardware event beats the clear by read
		lh_v = (i_rd ? '0 : q_r) | i_hw;
		ll_v = (i_rd ? '1 : q_r) & i_hw;
		q_nxt = (rw_v & RW_MASK) | (sc_v & SC_MASK) | (lh_v & LH_MASK)
			| (ll_v & LL_MASK) | (i_hw & RO_MASK);
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			q_r <= RESET;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign o_q = q_r;

	chk_latch_high_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		((i_hw & LH_MASK) != '0) |=> ((o_q & $past(i_hw) & LH_MASK) == ($past(i_hw) & LH_MASK)))
		else $error("latch-high bit lost its event");

	chk_self_clear_drop: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_wr |=> ##1 ((o_q & SC_MASK) == '0) || $past(i_wr))
		else $error("self-clearing bit did not clear");

	chk_ro_follow_hw: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		$past(i_rst_n) |-> ((o_q & RO_MASK) == ($past(i_hw) & RO_MASK)))
		else $error("read-only bits do not follow the hardware value");

endmodule
`default_nettype wire

// ===== mip_mgr_model.sv
// station manager model: issues single-cycle reads and writes of the portal slots
// drives at the falling edge, answers are sampled at falling edges too
`timescale 1ns/10ps
`default_nettype none
module mip_mgr_model (
	input wire logic i_clk_sys,
	output var mip_pkg::mip_req_s o_req,
	input wire mip_pkg::mip_rsp_s i_rsp
);
	initial o_req = '0;
	// released address and data lines flip so a stale value never looks valid
	task automatic drop_req();
		o_req.rd = 1'b0;
		o_req.wr = 1'b0;
		o_req.addr = ~o_req.addr;
		o_req.wdata = ~o_req.wdata;
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] v);
		@(negedge i_clk_sys);
		o_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
		@(negedge i_clk_sys);
		drop_req();
	endtask
	task automatic rd(input logic [4:0] a, output logic [15:0] v);
		int n;
		n = 0;
		@(negedge i_clk_sys);
		o_req.rd = 1'b1;
		o_req.wr = 1'b0;
		o_req.addr = a;
		@(negedge i_clk_sys);
		drop_req();
		while (i_rsp.valid !== 1'b1 && n < 4) begin
			@(negedge i_clk_sys);
			n++;
		end
		v = (i_rsp.valid === 1'b1) ? i_rsp.data : 16'hxxxx;
	endtask
endmodule
`default_nettype wire

// ===== mip_pkg.sv
// types shared by the extended register portal design files
// register numbers live in mip_regs.svh
package mip_pkg;

	typedef enum logic [1:0] {
		MIP_FN_ADDR = 2'h0,
		MIP_FN_DATA = 2'h1,
		MIP_FN_INC_RW = 2'h2,
		MIP_FN_INC_WR = 2'h3
	} mip_func_e;

	typedef struct packed {
		mip_func_e func;
		logic [8:0] rsvd;
		logic [4:0] space;
	} mip_ctrl_s;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [4:0] addr;
		logic [15:0] wdata;
	} mip_req_s;

	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} mip_rsp_s;

	typedef struct packed {
		mip_ctrl_s ctrl;
		logic [31:0][15:0] held_addr;
		mip_rsp_s rsp;
		logic [4:0] tx_drive;
	} mip_state_s;

endpackage

// ===== mip_portal.sv
// extended register portal: control and address/data slots of the management register set
// requests arrive decoded from the management framer on the same clock, at most one per cycle
// Summary of operation
// - indirect reach to 32 extended spaces of 65,536 registers, 16 bits each
// - function code 00 selects address mode, 01 data with no increment
// - code 10 advances the held address after every data read and write
// - code 11 advances the held address after data writes only
// - control bits 13..5 are written as zero and carry no meaning
// - low five control bits pick the extended space, reset zero
// - diagnostic pulse amplitude resets to 0x2 small, 0x7 gives a large pulse
// - seven-bit read-only signal quality in bits 14..8, lower is better
// - transmit amplitude setting acts inversely on drive level
// - fields support read/write, read-only, self-clearing, latch-high and latch-low
`timescale 1ns/10ps
`default_nettype none
`include "mip_regs.svh"

module mip_portal (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire mip_pkg::mip_req_s i_req,
	input wire logic [6:0] i_signal_quality_index,
	input wire logic [4:0] i_tx_amp_adjust,
	output var mip_pkg::mip_rsp_s o_rsp,
	output var logic [3:0] o_cable_diagnostic_pulse_amp,
	output var logic [4:0] o_tx_drive_level
);

	logic [1:0] rst_pipe_r;
	logic rst_n;
	mip_pkg::mip_state_s st_r;
	mip_pkg::mip_state_s st_nxt;

	logic hit_ctrl;
	logic hit_data;
	logic wr_ctrl;
	logic wr_data;
	logic rd_data;
	logic data_mode;
	logic ext_wr;
	logic ext_rd;
	logic do_inc;
	logic [4:0] cur_space;
	logic [15:0] cur_addr;
	logic sel_rsvd1;
	logic sel_rsvd2;
	logic sel_afe;
	logic sel_sq;
	logic [15:0] q_rsvd1;
	logic [15:0] q_afe;
	logic [15:0] q_sq;
	logic [15:0] ext_rdata;

	// reset enters asynchronously, leaves synchronously
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_pipe_r <= 2'h0;
		end else begin
			rst_pipe_r <= {rst_pipe_r[0], 1'b1};
		end
	end
	assign rst_n = rst_pipe_r[1];

	// request decode
	assign hit_ctrl = (i_req.addr == `MIP_OFF_CTRL);
	assign hit_data = (i_req.addr == `MIP_OFF_DATA);
	assign wr_ctrl = i_req.wr & hit_ctrl;
	assign wr_data = i_req.wr & hit_data;
	assign rd_data = i_req.rd & hit_data;
	// only the function field selects data mode, reserved bits are just stored
	assign data_mode = (st_r.ctrl.func != mip_pkg::MIP_FN_ADDR);
	assign ext_wr = wr_data & data_mode;
	assign ext_rd = rd_data & data_mode;
	assign cur_space = st_r.ctrl.space;
	assign cur_addr = st_r.held_addr[cur_space];

	always_comb begin
		unique case (st_r.ctrl.func)
			mip_pkg::MIP_FN_INC_RW: do_inc = ext_rd | ext_wr;
			mip_pkg::MIP_FN_INC_WR: do_inc = ext_wr;
			default: do_inc = 1'b0;
		endcase
	end

	// extended registers that are decoded; the rest read zero and drop writes
	assign sel_rsvd1 = (cur_space == `MIP_SPACE_RSVD) && (cur_addr == `MIP_XREG_RSVD1);
	assign sel_rsvd2 = (cur_space == `MIP_SPACE_RSVD) && (cur_addr == `MIP_XREG_RSVD2);
	assign sel_afe = (cur_space == `MIP_SPACE_AFE) && (cur_addr == `MIP_XREG_AFE);
	assign sel_sq = (cur_space == `MIP_SPACE_SQ) && (cur_addr == `MIP_XREG_SQ);

	mip_field #(
		.RESET(`MIP_RSVD1_RST),
		.RW_MASK(`MIP_RSVD1_RW_MASK),
		.SC_MASK(`MIP_NONE_MASK),
		.LH_MASK(`MIP_NONE_MASK),
		.LL_MASK(`MIP_NONE_MASK)
	) u_rsvd1 (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(rst_n),
		.i_wr(ext_wr & sel_rsvd1),
		.i_wdata(i_req.wdata),
		.i_rd(ext_rd & sel_rsvd1),
		.i_hw(`MIP_RSVD1_RST),
		.o_q(q_rsvd1)
	);

	mip_field #(
		.RESET(`MIP_AFE_RST),
		.RW_MASK(`MIP_AFE_RW_MASK),
		.SC_MASK(`MIP_NONE_MASK),
		.LH_MASK(`MIP_NONE_MASK),
		.LL_MASK(`MIP_NONE_MASK)
	) u_afe (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(rst_n),
		.i_wr(ext_wr & sel_afe),
		.i_wdata(i_req.wdata),
		.i_rd(ext_rd & sel_afe),
		.i_hw(`MIP_AFE_RST),
		.o_q(q_afe)
	);

	mip_field #(
		.RESET(`MIP_SQ_RST),
		.RW_MASK(`MIP_NONE_MASK),
		.SC_MASK(`MIP_NONE_MASK),
		.LH_MASK(`MIP_NONE_MASK),
		.LL_MASK(`MIP_NONE_MASK)
	) u_sq (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(rst_n),
		.i_wr(1'b0),
		.i_wdata(i_req.wdata),
		.i_rd(ext_rd & sel_sq),
		.i_hw({1'b0, i_signal_quality_index, 8'h00}),
		.o_q(q_sq)
	);

	always_comb begin
		ext_rdata = 16'h0000;
		if (sel_rsvd1) begin
			ext_rdata = q_rsvd1;
		end else if (sel_rsvd2) begin
			ext_rdata = `MIP_RSVD2_VAL;
		end else if (sel_afe) begin
			ext_rdata = q_afe;
		end else if (sel_sq) begin
			ext_rdata = q_sq;
		end
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.rsp.valid = 1'b0;
		if (wr_ctrl) begin
			st_nxt.ctrl = mip_pkg::mip_ctrl_s'(i_req.wdata);
		end
		if (wr_data && !data_mode) begin
			st_nxt.held_addr[cur_space] = i_req.wdata;
		end
		if (do_inc) begin
			// 16-bit sum drops the carry so the top address wraps to zero
			st_nxt.held_addr[cur_space] = cur_addr + 16'h0001;
		end
		if (i_req.rd) begin
			st_nxt.rsp.valid = 1'b1;
			if (hit_ctrl) begin
				st_nxt.rsp.data = 16'(st_r.ctrl);
			end else if (hit_data) begin
				st_nxt.rsp.data = data_mode ? ext_rdata : cur_addr;
			end else begin
				st_nxt.rsp.data = 16'h0000;
			end
		end
		// larger setting, weaker drive
		st_nxt.tx_drive = 5'(`MIP_TXAMP_MAX - i_tx_amp_adjust);
	end

	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
			st_r.tx_drive <= `MIP_TXAMP_MAX;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_rsp = st_r.rsp;
	assign o_cable_diagnostic_pulse_amp = q_afe[`MIP_PULSE_MSB:`MIP_PULSE_LSB];
	assign o_tx_drive_level = st_r.tx_drive;

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!rst_n);

	sequence s_ctrl_write;
		i_req.wr && hit_ctrl && !i_req.rd;
	endsequence

	sequence s_ctrl_read;
		i_req.rd && hit_ctrl && !i_req.wr;
	endsequence

	chk_rsp_one_cycle: assert property (
		i_req.rd |=> o_rsp.valid ##1 (o_rsp.valid == $past(i_req.rd)))
		else $error("read answer not one cycle after request");

	// a write, a quiet cycle, then the read back
	chk_ctrl_readback: assert property (
		s_ctrl_write ##1 !wr_ctrl ##1 s_ctrl_read |=> o_rsp.data == $past(i_req.wdata, 3))
		else $error("control register did not read back");

	chk_addr_mode_store: assert property (
		(wr_data && !data_mode && !wr_ctrl) |=>
		st_r.held_addr[$past(cur_space)] == $past(i_req.wdata))
		else $error("address mode write not stored");

	chk_no_inc_data: assert property (
		((ext_rd || ext_wr) && st_r.ctrl.func == mip_pkg::MIP_FN_DATA) |=>
		st_r.held_addr[$past(cur_space)] == $past(cur_addr))
		else $error("held address moved without post increment");

	chk_inc_rw_read: assert property (
		(ext_rd && st_r.ctrl.func == mip_pkg::MIP_FN_INC_RW) |=>
		st_r.held_addr[$past(cur_space)] == 16'($past(cur_addr) + 16'h0001))
		else $error("read did not advance held address");

	chk_inc_wr_only: assert property (
		(ext_rd && !ext_wr && st_r.ctrl.func == mip_pkg::MIP_FN_INC_WR) |=>
		st_r.held_addr[$past(cur_space)] == $past(cur_addr))
		else $error("read advanced address in write-only increment mode");

	chk_inc_on_write: assert property (
		(ext_wr && st_r.ctrl.func[1]) |=>
		st_r.held_addr[$past(cur_space)] == 16'($past(cur_addr) + 16'h0001))
		else $error("write did not advance held address");

	// answer carries the quality sampled the cycle before the read
	chk_sq_read: assert property (
		(ext_rd && sel_sq) |=>
		o_rsp.data[`MIP_SQ_MSB:`MIP_SQ_LSB] == $past(i_signal_quality_index, 2))
		else $error("signal quality read mismatch");

	chk_pulse_reset: assert property (
		$rose(rst_n) |-> o_cable_diagnostic_pulse_amp == `MIP_PULSE_SMALL)
		else $error("pulse amplitude reset value wrong");

	chk_tx_inverse: assert property (
		($past(i_tx_amp_adjust) > i_tx_amp_adjust) |=>
		(o_tx_drive_level > $past(o_tx_drive_level)))
		else $error("transmit drive not inverse of setting");

	// address writes touch the selected space only
	sequence s_addr_write;
		wr_data && !data_mode;
	endsequence

	chk_other_space_kept: assert property (
		s_addr_write |=> st_r.held_addr[$past(cur_space) ^ 5'h01] ==
		$past(st_r.held_addr[cur_space ^ 5'h01]))
		else $error("address write disturbed another space");

	chk_ctrl_fields: assert property (
		wr_ctrl |=> (cur_space == $past(i_req.wdata[`MIP_SPACE_MSB:`MIP_SPACE_LSB]))
		&& (st_r.ctrl.func == $past(i_req.wdata[`MIP_FUNC_MSB:`MIP_FUNC_LSB])))
		else $error("control fields not taken from write");

	chk_addr_mode_read: assert property (
		(rd_data && !data_mode) |=> o_rsp.data == $past(cur_addr))
		else $error("address mode read did not return held address");

	chk_rsvd2_zero: assert property (
		(ext_rd && sel_rsvd2) |=> o_rsp.data == `MIP_RSVD2_VAL)
		else $error("read-only reserved register not zero");

	chk_rsvd1_upper_ro: assert property (
		(ext_wr && sel_rsvd1) |=>
		(q_rsvd1 & ~`MIP_RSVD1_RW_MASK) == (`MIP_RSVD1_RST & ~`MIP_RSVD1_RW_MASK))
		else $error("read-only byte took write data");

	chk_pulse_large: assert property (
		(ext_wr && sel_afe && i_req.wdata[`MIP_PULSE_MSB:`MIP_PULSE_LSB] == `MIP_PULSE_LARGE)
		|=> o_cable_diagnostic_pulse_amp == `MIP_PULSE_LARGE)
		else $error("pulse amplitude not set large");

	// a write to the live quality field must not stick
	chk_sq_write_ignored: assert property (
		(ext_wr && sel_sq) |=>
		q_sq[`MIP_SQ_MSB:`MIP_SQ_LSB] == $past(i_signal_quality_index))
		else $error("signal quality field took write data");

	// carry out of the top address is dropped on purpose
	chk_addr_wrap: assert property (
		(do_inc && cur_addr == 16'hffff) |=> st_r.held_addr[$past(cur_space)] == 16'h0000)
		else $error("held address did not wrap to zero");

	chk_rsp_idle: assert property (
		!i_req.rd |=> !o_rsp.valid)
		else $error("read answer without a request");

endmodule
`default_nettype wire

// ===== mip_regs.svh
// register offsets, field positions and reset values of the extended register portal
// included by the portal design files and the bench; definitions only
`ifndef MIP_REGS_SVH
`define MIP_REGS_SVH

// standard register slots of the portal
`define MIP_OFF_CTRL 5'h0d
`define MIP_OFF_DATA 5'h0e

// portal control layout
`define MIP_CTRL_RST 16'h0000
`define MIP_FUNC_MSB 15
`define MIP_FUNC_LSB 14
`define MIP_SPACE_MSB 4
`define MIP_SPACE_LSB 0

// extended device spaces and registers that are decoded
`define MIP_SPACE_RSVD 5'h07
`define MIP_SPACE_AFE 5'h1b
`define MIP_SPACE_SQ 5'h1c
`define MIP_XREG_RSVD1 16'h003c
`define MIP_XREG_RSVD2 16'h003d
`define MIP_XREG_AFE 16'h0000
`define MIP_XREG_SQ 16'h00ac

// field masks and reset values
`define MIP_RSVD1_RW_MASK 16'h00ff
`define MIP_RSVD1_RST 16'h0000
`define MIP_RSVD2_VAL 16'h0000
`define MIP_AFE_RW_MASK 16'hffff
`define MIP_AFE_RST 16'h0020
`define MIP_PULSE_MSB 7
`define MIP_PULSE_LSB 4
`define MIP_PULSE_SMALL 4'h2
`define MIP_PULSE_LARGE 4'h7
`define MIP_SQ_MSB 14
`define MIP_SQ_LSB 8
`define MIP_SQ_RST 16'h0000
`define MIP_NONE_MASK 16'h0000

// transmit amplitude adjustment
`define MIP_TXAMP_MAX 5'h1f

`endif

// ===== mmd_indirect_register_portal_bench.sv
// self-checking bench of the extended register portal
// manager model drives requests; quality and amplitude inputs are randomised
`timescale 1ns/10ps
`default_nettype none
`include "mip_regs.svh"
module mmd_indirect_register_portal_bench;
	logic i_clk_sys = 1'b0;
	logic i_nrst = 1'b0;
	logic [6:0] sq = 7'h00;
	logic [4:0] adj = 5'h00;
	mip_pkg::mip_req_s req;
	mip_pkg::mip_rsp_s rsp;
	logic [3:0] amp;
	logic [4:0] drv;
	int fail_count = 0;
	int cmp_count = 0;
	int seed = 37501;
	logic [15:0] d;
	always #12.5 i_clk_sys = ~i_clk_sys;
	mip_portal u_dut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_req(req),
		.i_signal_quality_index(sq), .i_tx_amp_adjust(adj), .o_rsp(rsp),
		.o_cable_diagnostic_pulse_amp(amp), .o_tx_drive_level(drv));
	mip_mgr_model u_mgr (.i_clk_sys(i_clk_sys), .o_req(req), .i_rsp(rsp));
	function automatic logic [15:0] exp_sq(input logic [6:0] v);
		return {1'b0, v, 8'h00};
	endfunction
	function automatic logic [15:0] exp_adr(input logic [15:0] a, input logic [1:0] f);
		return a + ((f == 2'h2) ? 16'h0003 : (f == 2'h3) ? 16'h0001 : 16'h0000);
	endfunction
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// reserved control bits always written as zero
	task automatic xsel(input logic [4:0] s, input logic [1:0] f);
		u_mgr.wr(`MIP_OFF_CTRL, {f, 9'h000, s});
	endtask
	task automatic xset(input logic [4:0] s, input logic [15:0] a);
		xsel(s, 2'h0);
		u_mgr.wr(`MIP_OFF_DATA, a);
	endtask
	task automatic xrd(input logic [15:0] exp, input string what);
		u_mgr.rd(`MIP_OFF_DATA, d);
		check(d, exp, what);
	endtask
	task automatic summarize();
		$display("mismatches %0d comparisons %0d", fail_count, cmp_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#50us;
		fail_count++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		summarize();
	end
	initial begin
		repeat (4) @(negedge i_clk_sys);
		i_nrst = 1'b1;
		repeat (3) @(negedge i_clk_sys);
		u_mgr.rd(`MIP_OFF_CTRL, d);
		check(d, 16'h0000, "control reset");
		check({12'h000, amp}, 16'h0002, "pulse reset");
		u_mgr.rd(5'h03, d);
		check(d, 16'h0000, "unmapped slot");
		u_mgr.wr(`MIP_OFF_CTRL, 16'hc015);
		u_mgr.rd(`MIP_OFF_CTRL, d);
		check(d, 16'hc015, "control readback");
		xset(5'h07, 16'h003c);
		xsel(5'h07, 2'h1);
		u_mgr.wr(`MIP_OFF_DATA, 16'h0002);
		xrd(16'h0002, "space 7 reg 3c");
		u_mgr.wr(`MIP_OFF_DATA, 16'hffff);
		xrd(16'h00ff, "3c read-only upper byte");
		xsel(5'h07, 2'h0);
		xrd(16'h003c, "no increment in data mode");
		u_mgr.wr(`MIP_OFF_DATA, 16'h003d);
		xrd(16'h003d, "address slot reach");
		xsel(5'h07, 2'h1);
		u_mgr.wr(`MIP_OFF_DATA, 16'hffff);
		xrd(16'h0000, "3d read-only");
		sq = 7'($random(seed));
		for (int f = 1; f < 4; f++) begin
			xset(5'h1c, 16'h00ab);
			xsel(5'h1c, f[1:0]);
			xrd(16'h0000, "unsupported reg ab");
			xrd((f == 2) ? exp_sq(sq) : 16'h0000, "second read");
			u_mgr.wr(`MIP_OFF_DATA, 16'h1234);
			xsel(5'h1c, 2'h0);
			xrd(exp_adr(16'h00ab, f[1:0]), "held address after traffic");
		end
		xset(5'h1f, 16'hffff);
		xsel(5'h1f, 2'h2);
		xrd(16'h0000, "top register");
		xsel(5'h1f, 2'h0);
		xrd(16'h0000, "address wrap");
		xsel(5'h07, 2'h0);
		xrd(16'h003d, "per-space held address");
		xset(5'h1b, 16'h0000);
		xsel(5'h1b, 2'h1);
		xrd(16'h0020, "pulse register reset");
		u_mgr.wr(`MIP_OFF_DATA, 16'h0070);
		@(negedge i_clk_sys);
		check({12'h000, amp}, 16'h0007, "large pulse");
		xset(5'h1c, 16'h00ac);
		xsel(5'h1c, 2'h1);
		u_mgr.wr(`MIP_OFF_DATA, 16'hffff);
		repeat (20) begin
			sq = 7'($random(seed));
			adj = 5'($random(seed));
			xrd(exp_sq(sq), "live quality");
			check({11'h000, drv}, {11'h000, 5'h1f - adj}, "inverse drive");
		end
		summarize();
	end
endmodule
`default_nettype wire
